// ---- src/nce_defs.svh ----
`ifndef NCE_DEFS_SVH
`define NCE_DEFS_SVH

// Register byte offsets on the Avalon-MM slave.
`define NCE_REG_INSTR 5'h00
`define NCE_REG_STATUS 5'h04
`define NCE_REG_PC 5'h08
`define NCE_REG_POINTER 5'h0C
`define NCE_REG_SHIFT 5'h10
`define NCE_REG_DISCRETE 5'h14
`define NCE_REG_RAMDATA 5'h18

// Field positions in the pointer register.
`define NCE_PTR_CARRY_BIT 8

// Reset values.
`define NCE_PC_RESET 11'h000
`define NCE_NIB_RESET 4'h0

// Fixed page pattern loaded by the single-word call.
`define NCE_CALL_PAGE 4'h8

// Number of discrete output lines.
`define NCE_NUM_DISCRETE 10

// Bus answer latency in cycles after the request rises.
`define NCE_BUS_WAIT 1

`endif

// ---- src/nce_pkg.sv ----
package nce_pkg;

  typedef logic [10:0] nce_pc_t;
  typedef logic [3:0] nce_nib_t;

  typedef enum logic [4:0] {
    nop_op,
    swap_work_scratch_op,
    load_scratch_immediate_op,
    shift_in_one_op,
    shift_in_zero_op,
    set_ram_bit_op,
    clear_ram_bit_op,
    test_ram_bit_op,
    skip_on_carry_op,
    skip_on_ram_match_op,
    skip_on_immediate_match_op,
    skip_on_test_input_op,
    scratch_page_jump_op,
    indexed_jump_op,
    in_page_jump_op,
    call_fixed_page_op,
    return_op,
    return_skip_op,
    unmask_high_irq_op,
    mask_high_irq_op,
    unmask_low_irq_op,
    mask_low_irq_op,
    strobe_port_drive_on_op,
    strobe_port_drive_off_op,
    output_shift_to_strobe_op,
    output_scratch_pointer_op,
    drive_bidir_port_op,
    bidir_input_mode_op,
    read_bidir_port_op,
    set_discrete_op,
    clear_discrete_op
  } nce_op_t;

endpackage

// ---- src/nce_stack.sv ----
`timescale 1ns/100ps
module nce_stack #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 11
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] top
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 1 || WIDTH < 1) begin : g_chk
    $error("nce_stack: DEPTH and WIDTH must be at least one");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] ptr_r;
  logic [PW-1:0] ptr_dec;

  // Circular storage: overflow overwrites the oldest return address.
  always_comb begin
    if (ptr_r == '0) begin
      ptr_dec = PW'(DEPTH - 1);
    end else begin
      ptr_dec = ptr_r - PW'(1);
    end
  end

  assign top = mem[ptr_dec];

  always_ff @(posedge mclk) begin
    if (rst) begin
      ptr_r <= '0;
    end else if (push) begin
      ptr_r <= (ptr_r == PW'(DEPTH - 1)) ? '0 : ptr_r + PW'(1);
    end else if (pop) begin
      ptr_r <= ptr_dec;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[ptr_r] <= din;
    end
  end
endmodule

// ---- src/nce_ram.sv ----
`timescale 1ns/100ps
module nce_ram #(
  parameter int WORDS = 96
) (
  input wire logic mclk,
  input wire logic [6:0] addr,
  input wire logic we,
  input wire logic [3:0] wdata,
  output logic [3:0] rdata
);
  if (WORDS < 1 || WORDS > 128) begin : g_chk
    $error("nce_ram: WORDS must lie between 1 and 128");
  end

  logic [3:0] mem [WORDS];
  logic hit;

  // Addresses past the last row read as zero and ignore writes.
  assign hit = ({25'h0000000, addr} < WORDS);
  assign rdata = hit ? mem[addr] : 4'h0;

  always_ff @(posedge mclk) begin
    if (we && hit) begin
      mem[addr] <= wdata;
    end
  end
endmodule

// ---- src/nce_core.sv ----
// Function
// [RULE1] Swap work and scratch nibbles, one cycle.
// [RULE2] Load scratch nibble from immediate bits.
// [RULE3] Shift strobe register up, constant enters bit0.
// [RULE4] Set or clear opcode-selected RAM bit.
// [RULE5] Test RAM bit, skip when one.
// [RULE6] Skip next instruction when carry set.
// [RULE7] Skip when work equals RAM nibble.
// [RULE8] Skip when work equals immediate nibble.
// [RULE9] Skip when test input line is one.
// [RULE10] Jump: page from scratch, low seven immediate.
// [RULE11] Indexed jump ORs work into low nibble.
// [RULE12] In-page jump replaces low seven bits only.
// [RULE13] Call pushes counter, jumps to fixed page.
// [RULE14] Enable or disable each interrupt independently.
// [RULE15] Strobe port drive on/off, copy shift register.
// [RULE16] Strobe port gets scratch and pointer column.
// [RULE17] Bidir port drive, input mode, read.
// [RULE18] Ten discrete lines, each set or cleared.
// [RULE19] High interrupt wins, disables both; low disables itself.
// [RULE20] Strobe shift register is eight bits wide.
// [RULE21] Return pops stack; return-skip advances one more.
// [RULE22] True skip suppresses the next instruction word.
`timescale 1ns/100ps
`include "nce_defs.svh"
module nce_core #(
  parameter int STACK_DEPTH = 4,
  parameter int RAM_WORDS = 96,
  parameter nce_pkg::nce_pc_t HI_VECTOR = 11'h010,
  parameter nce_pkg::nce_pc_t LO_VECTOR = 11'h020
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic test_input_line,
  input wire logic high_priority_irq_line,
  input wire logic low_priority_irq_line,
  input wire logic [3:0] bidir_in,
  output logic [3:0] bidir_out,
  output logic [3:0] bidir_oe,
  output logic [7:0] strobe_port,
  output logic strobe_port_oe,
  output logic [9:0] discrete_output_lines
);
  import nce_pkg::*;

  if (STACK_DEPTH < 1 || RAM_WORDS < 1 || RAM_WORDS > 128) begin : g_chk
    $error("nce_core: unsupported stack depth or RAM size");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: every access waits one cycle, then completes.

  logic ack_r;
  logic [31:0] readdata_r;
  logic wr_go;
  logic exec;
  logic do_op;

  assign waitrequest = (read | write) & ~ack_r;
  assign readdata = readdata_r;
  // Partial-word writes are ignored.
  assign wr_go = write & ack_r & (byteenable == 4'hF);
  assign exec = wr_go & (address == `NCE_REG_INSTR);

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (read | write) & ~ack_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode.

  logic [9:0] opc;
  nce_op_t op;
  logic [6:0] imm7;
  logic [3:0] imm4;
  logic [1:0] bsel;

  assign opc = writedata[9:0];
  assign imm7 = opc[6:0];
  assign imm4 = opc[3:0];
  assign bsel = opc[1:0];

  function automatic nce_op_t decode(input logic [9:0] w);
    nce_op_t d;
    d = nop_op;
    casez (w)
      10'b1?????????: d = call_fixed_page_op;
      10'b011???????: d = in_page_jump_op;
      10'b010???????: d = scratch_page_jump_op;
      10'b001???????: d = indexed_jump_op;
      10'b0000001???: d = load_scratch_immediate_op;
      10'b0000010???: d = skip_on_immediate_match_op;
      10'b00000110??: d = set_ram_bit_op;
      10'b00000111??: d = clear_ram_bit_op;
      10'b00001000??: d = test_ram_bit_op;
      10'b0001000???: d = set_discrete_op;
      10'b0001001???: d = clear_discrete_op;
      10'b0000000???, 10'b0000110???, 10'b0000111???: d = nop_op;
      default: d = nop_op;
    endcase
    if (w[9:4] == 6'h01 || w[9:4] == 6'h02) begin
      d = w[4] ? load_scratch_immediate_op : skip_on_immediate_match_op;
    end
    if (w[9:4] == 6'h04) begin
      d = w[3] ? test_ram_bit_op : (w[2] ? clear_ram_bit_op : set_ram_bit_op);
    end
    if (w[9:4] == 6'h05) begin
      d = set_discrete_op;
    end
    if (w[9:4] == 6'h06) begin
      d = clear_discrete_op;
    end
    if (w[9:4] == 6'h00) begin
      unique case (w[3:0])
        4'h0: d = nop_op;
        4'h1: d = swap_work_scratch_op;
        4'h2: d = shift_in_one_op;
        4'h3: d = shift_in_zero_op;
        4'h4: d = skip_on_carry_op;
        4'h5: d = skip_on_ram_match_op;
        4'h6: d = skip_on_test_input_op;
        4'h7: d = return_op;
        4'h8: d = return_skip_op;
        4'h9: d = unmask_high_irq_op;
        4'hA: d = mask_high_irq_op;
        4'hB: d = unmask_low_irq_op;
        4'hC: d = mask_low_irq_op;
        4'hD: d = strobe_port_drive_on_op;
        4'hE: d = strobe_port_drive_off_op;
        4'hF: d = output_shift_to_strobe_op;
      endcase
    end
    if (w[9:4] == 6'h07) begin
      unique case (w[3:0])
        4'h0: d = output_scratch_pointer_op;
        4'h1: d = drive_bidir_port_op;
        4'h2: d = bidir_input_mode_op;
        4'h3: d = read_bidir_port_op;
        default: d = nop_op;
      endcase
    end
    return d;
  endfunction

  assign op = decode(opc);

  ////////////////////////////////////////////////////////////////////////////
  // Core state.

  nce_pc_t pc_r;
  nce_pc_t pc_inc;
  nce_pc_t stack_top;
  nce_nib_t work_nibble_r;
  nce_nib_t scratch_nibble_register_r;
  logic [6:0] ram_pointer_r;
  logic carry_r;
  logic skip_r;
  logic skip_cond;
  logic [7:0] shift_r;
  logic hi_en_r;
  logic lo_en_r;
  logic irq_go;
  logic irq_hi;
  logic [9:0] last_opc_r;
  logic [3:0] ram_rdata;
  logic [3:0] ram_wdata;
  logic ram_we;
  logic [3:0] bit_mask;

  // A skipped word is consumed as an ordinary instruction cycle.
  assign do_op = exec & ~skip_r;
  // The page bits are not touched by a low-counter wrap.
  assign pc_inc = {pc_r[10:7], pc_r[6:0] + 7'h01};
  assign bit_mask = 4'h1 << bsel;

  // Interrupts are only taken between bus accesses and never under a skip.
  assign irq_hi = high_priority_irq_line & hi_en_r;
  assign irq_go = ~(read | write) & ~skip_r & (irq_hi | (low_priority_irq_line & lo_en_r));

  always_comb begin
    unique case (op)
      // [RULE5] RAM bit test
      test_ram_bit_op: skip_cond = ram_rdata[bsel];
      // [RULE6] carry test
      skip_on_carry_op: skip_cond = carry_r;
      // [RULE7] RAM compare
      skip_on_ram_match_op: skip_cond = (work_nibble_r == ram_rdata);
      // [RULE8] immediate compare
      skip_on_immediate_match_op: skip_cond = (work_nibble_r == imm4);
      // [RULE9] test line sample
      skip_on_test_input_op: skip_cond = test_input_line;
      default: skip_cond = 1'b0;
    endcase
  end

  // [RULE22] skip flag
  always_ff @(posedge mclk) begin
    if (rst) begin
      skip_r <= 1'b0;
    end else if (exec) begin
      skip_r <= ~skip_r & skip_cond;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pc_r <= `NCE_PC_RESET;
    end else if (irq_go) begin
      pc_r <= irq_hi ? HI_VECTOR : LO_VECTOR;
    end else if (do_op) begin
      unique case (op)
        // [RULE10] scratch page jump
        scratch_page_jump_op: pc_r <= {scratch_nibble_register_r, imm7};
        // [RULE11] indexed branch
        indexed_jump_op: pc_r <= {pc_r[10:7], imm7[6:4], imm7[3:0] | work_nibble_r};
        // [RULE12] in-page jump
        in_page_jump_op: pc_r <= {pc_r[10:7], imm7};
        // [RULE13] fixed page call
        call_fixed_page_op: pc_r <= {`NCE_CALL_PAGE, imm7};
        // [RULE21] return paths
        return_op: pc_r <= stack_top;
        return_skip_op: pc_r <= {stack_top[10:7], stack_top[6:0] + 7'h01};
        default: pc_r <= pc_inc;
      endcase
    end else if (exec) begin
      pc_r <= pc_inc;
    end else if (wr_go && address == `NCE_REG_PC) begin
      pc_r <= writedata[10:0];
    end
  end

  // [RULE13] return address push
  nce_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(11)
  ) u_stack (
    .mclk(mclk),
    .rst(rst),
    .push(irq_go | (do_op & (op == call_fixed_page_op))),
    .pop(do_op & ((op == return_op) | (op == return_skip_op))),
    .din(irq_go ? pc_r : pc_inc),
    .top(stack_top)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      work_nibble_r <= `NCE_NIB_RESET;
      scratch_nibble_register_r <= `NCE_NIB_RESET;
    end else if (do_op) begin
      // [RULE1] one-cycle exchange
      if (op == swap_work_scratch_op) begin
        work_nibble_r <= scratch_nibble_register_r;
        scratch_nibble_register_r <= work_nibble_r;
      end
      // [RULE2] immediate load
      if (op == load_scratch_immediate_op) begin
        scratch_nibble_register_r <= imm4;
      end
      // [RULE17] bidir pin read
      if (op == read_bidir_port_op) begin
        work_nibble_r <= bidir_in;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ram_pointer_r <= 7'h00;
      carry_r <= 1'b0;
    end else if (wr_go && address == `NCE_REG_POINTER) begin
      ram_pointer_r <= writedata[6:0];
      carry_r <= writedata[`NCE_PTR_CARRY_BIT];
    end
  end

  // [RULE3] [RULE20] eight-bit serial shift
  always_ff @(posedge mclk) begin
    if (rst) begin
      shift_r <= 8'h00;
    end else if (do_op && (op == shift_in_one_op || op == shift_in_zero_op)) begin
      shift_r <= {shift_r[6:0], op == shift_in_one_op};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      strobe_port <= 8'h00;
      strobe_port_oe <= 1'b0;
    end else if (do_op) begin
      // [RULE15] strobe drive and copy
      if (op == strobe_port_drive_on_op) begin
        strobe_port_oe <= 1'b1;
      end
      if (op == strobe_port_drive_off_op) begin
        strobe_port_oe <= 1'b0;
      end
      if (op == output_shift_to_strobe_op) begin
        strobe_port <= shift_r;
      end
      // [RULE16] external RAM address out
      if (op == output_scratch_pointer_op) begin
        strobe_port <= {scratch_nibble_register_r, ram_pointer_r[3:0]};
      end
    end
  end

  // [RULE17] bidir drive and release
  always_ff @(posedge mclk) begin
    if (rst) begin
      bidir_out <= 4'h0;
      bidir_oe <= 4'h0;
    end else if (do_op && op == drive_bidir_port_op) begin
      bidir_out <= work_nibble_r;
      bidir_oe <= 4'hF;
    end else if (do_op && op == bidir_input_mode_op) begin
      bidir_oe <= 4'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      hi_en_r <= 1'b0;
      lo_en_r <= 1'b0;
    end else if (irq_go) begin
      // [RULE19] priority acceptance
      hi_en_r <= hi_en_r & ~irq_hi;
      lo_en_r <= 1'b0;
    end else if (do_op) begin
      // [RULE14] independent masks
      unique case (op)
        unmask_high_irq_op: hi_en_r <= 1'b1;
        mask_high_irq_op: hi_en_r <= 1'b0;
        unmask_low_irq_op: lo_en_r <= 1'b1;
        mask_low_irq_op: lo_en_r <= 1'b0;
        default: begin
        end
      endcase
    end
  end

  for (genvar i = 0; i < `NCE_NUM_DISCRETE; i++) begin : g_disc
    // [RULE18] per-line set and clear
    always_ff @(posedge mclk) begin
      if (rst) begin
        discrete_output_lines[i] <= 1'b0;
      end else if (do_op && imm4 == 4'(i) && op == set_discrete_op) begin
        discrete_output_lines[i] <= 1'b1;
      end else if (do_op && imm4 == 4'(i) && op == clear_discrete_op) begin
        discrete_output_lines[i] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data RAM.

  always_comb begin
    ram_we = 1'b0;
    ram_wdata = writedata[3:0];
    if (wr_go && address == `NCE_REG_RAMDATA) begin
      ram_we = 1'b1;
    end else if (do_op && op == set_ram_bit_op) begin
      // [RULE4] bit set
      ram_we = 1'b1;
      ram_wdata = ram_rdata | bit_mask;
    end else if (do_op && op == clear_ram_bit_op) begin
      // [RULE4] bit clear
      ram_we = 1'b1;
      ram_wdata = ram_rdata & ~bit_mask;
    end
  end

  nce_ram #(
    .WORDS(RAM_WORDS)
  ) u_ram (
    .mclk(mclk),
    .addr(ram_pointer_r),
    .we(ram_we),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read-back.

  always_ff @(posedge mclk) begin
    if (rst) begin
      last_opc_r <= 10'h000;
    end else if (exec) begin
      last_opc_r <= opc;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      readdata_r <= 32'h00000000;
    end else if (read && !ack_r) begin
      unique case (address)
        `NCE_REG_INSTR: readdata_r <= {22'h000000, last_opc_r};
        `NCE_REG_STATUS: readdata_r <= {5'h00, pc_r, 2'h0, bidir_oe[0], strobe_port_oe, lo_en_r, hi_en_r,
                                        skip_r, carry_r, scratch_nibble_register_r, work_nibble_r};
        `NCE_REG_PC: readdata_r <= {21'h000000, pc_r};
        `NCE_REG_POINTER: readdata_r <= {23'h000000, carry_r, 1'b0, ram_pointer_r};
        `NCE_REG_SHIFT: readdata_r <= {16'h0000, strobe_port, shift_r};
        `NCE_REG_DISCRETE: readdata_r <= {22'h000000, discrete_output_lines};
        `NCE_REG_RAMDATA: readdata_r <= {28'h0000000, ram_rdata};
        default: readdata_r <= 32'h00000000;
      endcase
    end
  end
endmodule

// ---- sim/nce_core_monitor.sv ----
`timescale 1ns/100ps
module nce_core_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  input wire logic test_input_line,
  input wire logic [3:0] bidir_oe,
  input wire logic [7:0] strobe_port,
  input wire logic strobe_port_oe,
  input wire logic [9:0] discrete_output_lines
);
  logic fire;
  logic strobe_load;
  logic [9:0] wd;
  logic [3:0] nsel;
  logic skip_maybe_r;
  logic skip_sure_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  assign fire = write && !waitrequest && address == 5'h00 && byteenable == 4'hF;
  assign wd = writedata[9:0];
  assign nsel = writedata[3:0];
  assign strobe_load = fire && (wd == 10'h00F || wd == 10'h070);
  // Any word that may leave a skip pending blocks the forward checks on the word after it.
  always_ff @(posedge mclk) begin
    if (rst) begin
      skip_maybe_r <= 1'h0;
      skip_sure_r <= 1'h0;
    end else if (fire) begin
      skip_maybe_r <= (wd inside {10'h004, 10'h005, 10'h006}) || wd[9:4] == 6'h02 || wd[9:3] == 7'h09;
      skip_sure_r <= wd == 10'h006 && test_input_line && !skip_maybe_r;
    end
  end
  sequence s_exec(logic [9:0] w);
    fire && !skip_maybe_r && wd == w;
  endsequence
  sequence s_disc(logic [5:0] g);
    fire && !skip_maybe_r && wd[9:4] == g && wd[3:0] < 4'hA;
  endsequence
  //////////////////////////////////////////////////
  AST_DISC_SET: assert property (s_disc(6'h05) |=>
    discrete_output_lines == ($past(discrete_output_lines) | (10'h001 << $past(nsel))))
    else $error("discrete line not set");
  AST_DISC_CLR: assert property (s_disc(6'h06) |=>
    discrete_output_lines == ($past(discrete_output_lines) & ~(10'h001 << $past(nsel))))
    else $error("discrete line not cleared");
  AST_OE_ON: assert property (s_exec(10'h00D) |=> strobe_port_oe)
    else $error("strobe drive not on");
  AST_OE_OFF: assert property (s_exec(10'h00E) |=> !strobe_port_oe)
    else $error("strobe drive not off");
  AST_BIDIR_DRV: assert property (s_exec(10'h071) |=> bidir_oe == 4'hF)
    else $error("nibble port not driving");
  AST_BIDIR_IN: assert property (s_exec(10'h072) |=> bidir_oe == 4'h0)
    else $error("nibble port not released");
  AST_SKIP_DROP: assert property (fire && skip_sure_r |=>
    $stable(discrete_output_lines) && $stable(strobe_port_oe) && $stable(bidir_oe))
    else $error("skipped word had an effect");
  AST_STROBE_CAUSE: assert property ($changed(strobe_port) |->
    $past(strobe_load) || $past(rst)) else $error("strobe port changed without load");
endmodule

bind nce_core nce_core_monitor u_monitor (.mclk(mclk), .rst(rst), .address(address), .write(write),
  .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
  .test_input_line(test_input_line), .bidir_oe(bidir_oe), .strobe_port(strobe_port),
  .strobe_port_oe(strobe_port_oe), .discrete_output_lines(discrete_output_lines));

// ---- sim/nce_ext_ram.sv ----
`timescale 1ns/100ps
module nce_ext_ram (
  input wire logic mclk,
  input wire logic [7:0] strobe_port,
  input wire logic strobe_port_oe,
  input wire logic [3:0] bidir_out,
  input wire logic [3:0] bidir_oe,
  output logic [3:0] bidir_in
);
  logic [3:0] mem [256];
  logic [3:0] last_r = 4'h0;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:4] ^ i[3:0] ^ 4'h9;
    end
  end
  // The strobe port addresses this memory; the nibble port carries its data.
  always @(posedge mclk) begin
    if (bidir_oe == 4'hF && strobe_port_oe) begin
      mem[strobe_port] <= bidir_out;
    end
    last_r <= bidir_in;
  end
  // Unselected, the floating nibble toggles so a stale value is never read as good.
  always_comb begin
    if (bidir_oe == 4'hF) begin
      bidir_in = bidir_out;
    end else if (strobe_port_oe) begin
      bidir_in = mem[strobe_port];
    end else begin
      bidir_in = ~last_r;
    end
  end
endmodule

// ---- sim/tb_nce_core.sv ----
`timescale 1ns/100ps
module tb_nce_core;
  import nce_pkg::*;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic [4:0] address = 5'h00;
  logic read = 1'h0;
  logic write = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata, rd;
  logic waitrequest;
  logic test_input_line = 1'h0;
  logic irq_hi = 1'h0;
  logic irq_lo = 1'h0;
  logic [3:0] bidir_in, bidir_out, bidir_oe;
  logic [7:0] strobe_port;
  logic strobe_port_oe;
  logic [9:0] discrete_output_lines;
  logic [9:0] disc_exp = 10'h000;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  nce_core DUT (.mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .test_input_line(test_input_line), .high_priority_irq_line(irq_hi), .low_priority_irq_line(irq_lo),
    .bidir_in(bidir_in), .bidir_out(bidir_out), .bidir_oe(bidir_oe), .strobe_port(strobe_port),
    .strobe_port_oe(strobe_port_oe), .discrete_output_lines(discrete_output_lines));
  nce_ext_ram u_ext (.mclk(mclk), .strobe_port(strobe_port), .strobe_port_oe(strobe_port_oe),
    .bidir_out(bidir_out), .bidir_oe(bidir_oe), .bidir_in(bidir_in));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  //////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count = bad_count + 1;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !wr;
    write <= wr;
    @(posedge mclk);
    while (waitrequest !== 1'h0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    rd = readdata;
    chk("bus_answer", 32'h1, {31'h0, n < 20});
    read <= 1'h0;
    write <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic exec(input logic [9:0] w);
    bus(1'h1, 5'h00, {22'h0, w}, 4'hF);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    bus(1'h0, a, 32'h0, 4'hF);
    chk(nm, e, rd & m);
  endtask
  task automatic skip_case(input logic [9:0] w, input logic s);
    exec(w);
    rdc(5'h04, 32'h200, {22'h0, s, 9'h0}, "skip_flag");
    if (s) begin
      exec(10'h050);
      chk("skipped_word", 32'h0, {22'h0, discrete_output_lines});
      rdc(5'h04, 32'h200, 32'h0, "skip_clear");
    end
  endtask
  //////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    rdc(5'h04, 32'hFFFFFFFF, 32'h0, "status_reset");
    rdc(5'h1C, 32'hFFFFFFFF, 32'h0, "unmapped");
    chk("pins_reset", 32'h0, {9'h0, discrete_output_lines, strobe_port, strobe_port_oe, bidir_oe});
    $display("test reset done");
    bus(1'h1, 5'h0C, 32'h6, 4'hF);
    exec(10'h01C);
    exec(10'h070);
    chk("strobe_ptr", 32'hC6, {24'h0, strobe_port});
    exec(10'h00D);
    chk("strobe_oe", 32'h1, {31'h0, strobe_port_oe});
    exec(10'h073);
    rdc(5'h04, 32'hFF, 32'hC3, "work_scratch");
    exec(10'h001);
    rdc(5'h04, 32'hFF, 32'h3C, "swap");
    exec(10'h071);
    chk("bidir_drive", 32'h1C, {27'h0, bidir_oe == 4'hF, bidir_out});
    exec(10'h001);
    exec(10'h072);
    chk("bidir_input", 32'h0, {28'h0, bidir_oe});
    exec(10'h073);
    rdc(5'h04, 32'hFF, 32'hCC, "bidir_read");
    $display("test ports done");
    exec(10'h002);
    exec(10'h003);
    exec(10'h002);
    rdc(5'h10, 32'hFF, 32'h05, "shift");
    for (int i = 0; i < 6; i++) exec(10'h003);
    rdc(5'h10, 32'hFF, 32'h40, "shift_width");
    exec(10'h00F);
    chk("strobe_copy", 32'h40, {24'h0, strobe_port});
    exec(10'h00E);
    chk("strobe_off", 32'h0, {31'h0, strobe_port_oe});
    $display("test shift done");
    for (int n = 0; n < 21; n++) begin
      exec(n < 10 ? 10'h050 + 10'(n) : (n == 10 ? 10'h05A : 10'h060 + 10'(n % 10)));
      if (n != 10) disc_exp[n % 10] = n < 10;
      chk("discrete", {22'h0, disc_exp}, {22'h0, discrete_output_lines});
    end
    $display("test discrete done");
    bus(1'h1, 5'h0C, 32'h112, 4'hF);
    bus(1'h1, 5'h18, 32'h0, 4'hF);
    exec(10'h042);
    rdc(5'h18, 32'hF, 32'h4, "ram_set");
    exec(10'h041);
    exec(10'h046);
    rdc(5'h18, 32'hF, 32'h2, "ram_clear");
    skip_case(10'h049, 1'h1);
    skip_case(10'h048, 1'h0);
    skip_case(10'h004, 1'h1);
    skip_case(10'h005, 1'h0);
    skip_case(10'h02C, 1'h1);
    skip_case(10'h02B, 1'h0);
    bus(1'h1, 5'h18, 32'hC, 4'hF);
    skip_case(10'h005, 1'h1);
    bus(1'h1, 5'h0C, 32'h012, 4'hF);
    skip_case(10'h004, 1'h0);
    test_input_line <= 1'h1;
    @(posedge mclk);
    skip_case(10'h006, 1'h1);
    test_input_line <= 1'h0;
    @(posedge mclk);
    skip_case(10'h006, 1'h0);
    $display("test skip done");
    bus(1'h1, 5'h08, 32'h305, 4'hF);
    bus(1'h1, 5'h08, 32'h7FF, 4'h3);
    exec(10'h000);
    rdc(5'h08, 32'h7FF, 32'h306, "pc_step");
    exec(10'h1AA);
    rdc(5'h08, 32'h7FF, 32'h32A, "pc_in_page");
    exec(10'h013);
    exec(10'h111);
    rdc(5'h08, 32'h7FF, 32'h191, "pc_scratch_page");
    exec(10'h0D1);
    rdc(5'h08, 32'h7FF, 32'h1DD, "pc_indexed");
    exec(10'h233);
    rdc(5'h08, 32'h7FF, 32'h433, "pc_call");
    exec(10'h007);
    rdc(5'h08, 32'h7FF, 32'h1DE, "pc_return");
    exec(10'h233);
    exec(10'h008);
    rdc(5'h08, 32'h7FF, 32'h1E0, "pc_return_skip");
    $display("test jump done");
    exec(10'h009);
    exec(10'h00B);
    exec(10'h00A);
    rdc(5'h04, 32'hC00, 32'h800, "irq_enable_a");
    exec(10'h009);
    exec(10'h00C);
    rdc(5'h04, 32'hC00, 32'h400, "irq_enable_b");
    exec(10'h00B);
    irq_hi <= 1'h1;
    irq_lo <= 1'h1;
    repeat (3) @(posedge mclk);
    irq_hi <= 1'h0;
    irq_lo <= 1'h0;
    @(posedge mclk);
    rdc(5'h04, 32'h07FF0C00, 32'h00100000, "irq_both");
    exec(10'h009);
    exec(10'h00B);
    irq_lo <= 1'h1;
    repeat (3) @(posedge mclk);
    irq_lo <= 1'h0;
    @(posedge mclk);
    rdc(5'h04, 32'h07FF0C00, 32'h00200400, "irq_low");
    $display("test interrupt done");
    end_of_test();
  end
endmodule
